// ===== verilog/scp_pkg.sv
// Behaviour
// - address counter steps on each selected config clock rise while enabled, stopping at terminal count
// - output-enable/reset low holds counter reset and floats serial data
// - open-drain output-enable/reset pulled low until power-on reset completes
// - chip enable high means standby, counter reset, data floated
// - cascade enable low only when enabled and counter passed terminal count
// - cascade enable returns high when output-enable/reset low or chip enable high
// - configure instruction pulses open-drain configuration pulse low
// - isp mode floats the serial data output
// - tap state follows tms sampled on each tck rise
// - tdi feeds every scan register, tdo delivers their serial output
// - tms and tdi synchronisers reset to one, so both read as one until the pins are first sampled
// - configuration pulse stays low at least the minimum pulse time
package scp_pkg;
   localparam int CLK_MHZ = 40;
   // =====================================================
   // timing
   localparam int POR_TIME_NS = 2000;
   localparam int POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CF_PULSE_MIN_NS = 300;
   localparam int CF_PULSE_CYCLES = (CF_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYCLES);
   localparam logic [CNT_W-1:0] CF_LOAD = CNT_W'(CF_PULSE_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   // =====================================================
   // storage
   localparam int MEM_BYTES = 64;
   localparam int BYTE_IDX_W = 6;
   localparam int ADDR_W = 9;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 9'h000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;
   localparam logic [ADDR_W-1:0] TERMINAL_COUNT = 9'h1FF;
   localparam logic [BYTE_IDX_W-1:0] PTR_ONE = 6'h01;
   // =====================================================
   // scan instructions
   localparam int IR_W = 8;
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
   localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;
   localparam logic [IR_W-1:0] INS_CONFIG = 8'hEE;
   localparam logic [IR_W-1:0] INS_ISP_MODE_ACTIVE = 8'hE8;
   localparam logic [IR_W-1:0] INS_PROGRAM = 8'hEA;
   localparam logic [IR_W-1:0] DR_CAPTURE = 8'h00;
   typedef enum logic [3:0] {
      TAP_EXIT2_DR = 4'h0, TAP_EXIT1_DR = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
      TAP_SEL_IR = 4'h4, TAP_UPDATE_DR = 4'h5, TAP_CAPTURE_DR = 4'h6, TAP_SEL_DR = 4'h7,
      TAP_EXIT2_IR = 4'h8, TAP_EXIT1_IR = 4'h9, TAP_SHIFT_IR = 4'hA, TAP_PAUSE_IR = 4'hB,
      TAP_IDLE = 4'hC, TAP_UPDATE_IR = 4'hD, TAP_CAPTURE_IR = 4'hE, TAP_RESET = 4'hF
   } scp_tap_t;
endpackage : scp_pkg

// ===== verilog/scp_tap_if.sv
`timescale 1ns/10ps
`default_nettype none
// signals between the readout core and its test access port
interface scp_tap_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic config_go;
   logic isp_mode_active;
   logic prog_stb;
   logic [scp_pkg::IR_W-1:0] prog_byte;
   modport core (output tck_rise, tck_fall, tms, tdi,
                 input tdo, tdo_oe, config_go, isp_mode_active, prog_stb, prog_byte);
   modport tap (input tck_rise, tck_fall, tms, tdi,
                output tdo, tdo_oe, config_go, isp_mode_active, prog_stb, prog_byte);
endinterface : scp_tap_if
`default_nettype wire

// ===== verilog/scp_tap.sv
`timescale 1ns/10ps
`default_nettype none
module scp_tap (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   scp_tap_if.tap t
);
   scp_pkg::scp_tap_t state_r, state_nxt;
   logic [scp_pkg::IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt, dr_r, dr_nxt;
   logic byp_r, byp_nxt, tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
   logic go_r, go_nxt, isp_r, isp_nxt, stb_r, stb_nxt;

   assign t.tdo = tdo_r;
   assign t.tdo_oe = tdo_oe_r;
   assign t.config_go = go_r;
   assign t.isp_mode_active = isp_r;
   assign t.prog_stb = stb_r;
   assign t.prog_byte = dr_r;

   // =====================================================
   // tap sequencing, shift paths and update actions
   always_comb begin
      state_nxt = state_r;
      ir_sh_nxt = ir_sh_r;
      ir_nxt = ir_r;
      dr_nxt = dr_r;
      byp_nxt = byp_r;
      tdo_nxt = tdo_r;
      tdo_oe_nxt = tdo_oe_r;
      go_nxt = 1'b0;
      isp_nxt = isp_r;
      stb_nxt = 1'b0;
      if (t.tck_rise) begin
         unique case (state_r)
            scp_pkg::TAP_RESET: state_nxt = t.tms ? scp_pkg::TAP_RESET : scp_pkg::TAP_IDLE;
            scp_pkg::TAP_IDLE: state_nxt = t.tms ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_IDLE;
            scp_pkg::TAP_SEL_DR: state_nxt = t.tms ? scp_pkg::TAP_SEL_IR : scp_pkg::TAP_CAPTURE_DR;
            scp_pkg::TAP_CAPTURE_DR: state_nxt = t.tms ? scp_pkg::TAP_EXIT1_DR : scp_pkg::TAP_SHIFT_DR;
            scp_pkg::TAP_SHIFT_DR: state_nxt = t.tms ? scp_pkg::TAP_EXIT1_DR : scp_pkg::TAP_SHIFT_DR;
            scp_pkg::TAP_EXIT1_DR: state_nxt = t.tms ? scp_pkg::TAP_UPDATE_DR : scp_pkg::TAP_PAUSE_DR;
            scp_pkg::TAP_PAUSE_DR: state_nxt = t.tms ? scp_pkg::TAP_EXIT2_DR : scp_pkg::TAP_PAUSE_DR;
            scp_pkg::TAP_EXIT2_DR: state_nxt = t.tms ? scp_pkg::TAP_UPDATE_DR : scp_pkg::TAP_SHIFT_DR;
            scp_pkg::TAP_UPDATE_DR: state_nxt = t.tms ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_IDLE;
            scp_pkg::TAP_SEL_IR: state_nxt = t.tms ? scp_pkg::TAP_RESET : scp_pkg::TAP_CAPTURE_IR;
            scp_pkg::TAP_CAPTURE_IR: state_nxt = t.tms ? scp_pkg::TAP_EXIT1_IR : scp_pkg::TAP_SHIFT_IR;
            scp_pkg::TAP_SHIFT_IR: state_nxt = t.tms ? scp_pkg::TAP_EXIT1_IR : scp_pkg::TAP_SHIFT_IR;
            scp_pkg::TAP_EXIT1_IR: state_nxt = t.tms ? scp_pkg::TAP_UPDATE_IR : scp_pkg::TAP_PAUSE_IR;
            scp_pkg::TAP_PAUSE_IR: state_nxt = t.tms ? scp_pkg::TAP_EXIT2_IR : scp_pkg::TAP_PAUSE_IR;
            scp_pkg::TAP_EXIT2_IR: state_nxt = t.tms ? scp_pkg::TAP_UPDATE_IR : scp_pkg::TAP_SHIFT_IR;
            scp_pkg::TAP_UPDATE_IR: state_nxt = t.tms ? scp_pkg::TAP_SEL_DR : scp_pkg::TAP_IDLE;
         endcase
         unique case (state_r)
            scp_pkg::TAP_RESET: begin
               ir_nxt = scp_pkg::INS_BYPASS;
               isp_nxt = 1'b0;
            end
            scp_pkg::TAP_CAPTURE_IR: ir_sh_nxt = scp_pkg::IR_CAPTURE;
            scp_pkg::TAP_SHIFT_IR: ir_sh_nxt = {t.tdi, ir_sh_r[scp_pkg::IR_W-1:1]};
            scp_pkg::TAP_UPDATE_IR: begin
               ir_nxt = ir_sh_r;
               go_nxt = (ir_sh_r == scp_pkg::INS_CONFIG);
               if (ir_sh_r == scp_pkg::INS_ISP_MODE_ACTIVE) begin
                  isp_nxt = 1'b1;
               end
            end
            scp_pkg::TAP_CAPTURE_DR: begin
               dr_nxt = scp_pkg::DR_CAPTURE;
               byp_nxt = 1'b0;
            end
            scp_pkg::TAP_SHIFT_DR: begin
               dr_nxt = {t.tdi, dr_r[scp_pkg::IR_W-1:1]};
               byp_nxt = t.tdi;
            end
            scp_pkg::TAP_UPDATE_DR: stb_nxt = isp_r && (ir_r == scp_pkg::INS_PROGRAM);
            default: ;
         endcase
      end
      // tdo changes on the falling tck edge, as the scan standard wants
      if (t.tck_fall) begin
         tdo_oe_nxt = (state_r == scp_pkg::TAP_SHIFT_IR) || (state_r == scp_pkg::TAP_SHIFT_DR);
         if (state_r == scp_pkg::TAP_SHIFT_IR) begin
            tdo_nxt = ir_sh_r[0];
         end else if (ir_r == scp_pkg::INS_PROGRAM) begin
            tdo_nxt = dr_r[0];
         end else begin
            tdo_nxt = byp_r;
         end
      end
   end

   // tap registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= scp_pkg::TAP_RESET;
         ir_sh_r <= scp_pkg::IR_CAPTURE;
         ir_r <= scp_pkg::INS_BYPASS;
         dr_r <= scp_pkg::DR_CAPTURE;
         byp_r <= 1'b0;
         tdo_r <= 1'b1;
         tdo_oe_r <= 1'b0;
         go_r <= 1'b0;
         isp_r <= 1'b0;
         stb_r <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         ir_sh_r <= ir_sh_nxt;
         ir_r <= ir_nxt;
         dr_r <= dr_nxt;
         byp_r <= byp_nxt;
         tdo_r <= tdo_nxt;
         tdo_oe_r <= tdo_oe_nxt;
         go_r <= go_nxt;
         isp_r <= isp_nxt;
         stb_r <= stb_nxt;
      end
   end
endmodule : scp_tap
`default_nettype wire

// ===== verilog/scp_readout.sv
`timescale 1ns/10ps
`default_nettype none
module scp_readout (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic cfg_clk,
   input wire logic cfg_clk_sel,
   input wire logic chip_enable_n,
   input wire logic oe_reset_n_i,
   output logic oe_reset_n_o,
   output logic oe_reset_n_oe,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic cascade_enable_out_n,
   output logic config_pulse_n_o,
   output logic config_pulse_n_oe,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe
);
   scp_tap_if tif ();

   // =====================================================
   // pin synchronisers; stage 1 only feeds stage 2
   logic [1:0] clk_s_r, sel_s_r, ce_s_r, oe_s_r, tck_s_r, tms_s_r, tdi_s_r;
   logic clk_d_r, tck_d_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clk_s_r <= 2'h0;
         sel_s_r <= 2'h0;
         ce_s_r <= 2'h3;
         oe_s_r <= 2'h0;
         tck_s_r <= 2'h0;
         tms_s_r <= 2'h3;
         tdi_s_r <= 2'h3;
         clk_d_r <= 1'b0;
         tck_d_r <= 1'b0;
      end else if (clk_en) begin
         clk_s_r <= {clk_s_r[0], cfg_clk};
         sel_s_r <= {sel_s_r[0], cfg_clk_sel};
         ce_s_r <= {ce_s_r[0], chip_enable_n};
         oe_s_r <= {oe_s_r[0], oe_reset_n_i};
         tck_s_r <= {tck_s_r[0], tck};
         tms_s_r <= {tms_s_r[0], tms};
         tdi_s_r <= {tdi_s_r[0], tdi};
         clk_d_r <= clk_s_r[1];
         tck_d_r <= tck_s_r[1];
      end
   end

   logic cfg_rise;
   assign cfg_rise = clk_s_r[1] && !clk_d_r;
   assign tif.tck_rise = tck_s_r[1] && !tck_d_r;
   assign tif.tck_fall = !tck_s_r[1] && tck_d_r;
   assign tif.tms = tms_s_r[1];
   assign tif.tdi = tdi_s_r[1];

   scp_tap u_tap (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .t(tif.tap)
   );

   assign tdo = tif.tdo; // registered inside the tap
   assign tdo_oe = tif.tdo_oe;

   // =====================================================
   // power-on reset hold and configuration pulse timers
   logic [scp_pkg::CNT_W-1:0] por_cnt_r, por_cnt_nxt, cf_cnt_r, cf_cnt_nxt;
   logic oe_rst_oe_r, oe_rst_oe_nxt, cf_oe_r, cf_oe_nxt;
   always_comb begin
      por_cnt_nxt = por_cnt_r;
      if (por_cnt_r != scp_pkg::CNT_ZERO) begin
         por_cnt_nxt = por_cnt_r - scp_pkg::CNT_ONE;
      end
      oe_rst_oe_nxt = (por_cnt_nxt != scp_pkg::CNT_ZERO);
      cf_cnt_nxt = cf_cnt_r;
      if (tif.config_go) begin
         cf_cnt_nxt = scp_pkg::CF_LOAD;
      end else if (cf_cnt_r != scp_pkg::CNT_ZERO) begin
         cf_cnt_nxt = cf_cnt_r - scp_pkg::CNT_ONE;
      end
      cf_oe_nxt = (cf_cnt_nxt != scp_pkg::CNT_ZERO);
   end

   // timer registers; the drive level of both open-drain pins is a fixed low
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         por_cnt_r <= scp_pkg::POR_LOAD;
         oe_rst_oe_r <= 1'b1;
         cf_cnt_r <= scp_pkg::CNT_ZERO;
         cf_oe_r <= 1'b0;
         oe_reset_n_o <= 1'b0;
         config_pulse_n_o <= 1'b0;
      end else if (clk_en) begin
         por_cnt_r <= por_cnt_nxt;
         oe_rst_oe_r <= oe_rst_oe_nxt;
         cf_cnt_r <= cf_cnt_nxt;
         cf_oe_r <= cf_oe_nxt;
         oe_reset_n_o <= 1'b0;
         config_pulse_n_o <= 1'b0;
      end
   end
   assign oe_reset_n_oe = oe_rst_oe_r;
   assign config_pulse_n_oe = cf_oe_r;

   // =====================================================
   // bit store, loaded byte by byte through the program scan register
   logic [scp_pkg::IR_W-1:0] mem_r [scp_pkg::MEM_BYTES];
   logic [scp_pkg::BYTE_IDX_W-1:0] ptr_r, ptr_nxt;
   always_comb begin
      ptr_nxt = ptr_r;
      if (!tif.isp_mode_active) begin
         ptr_nxt = '0;
      end else if (tif.prog_stb) begin
         ptr_nxt = ptr_r + scp_pkg::PTR_ONE;
      end
   end

   // no reset on the array: it is storage, the pointer alone is control
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ptr_r <= '0;
      end else if (clk_en) begin
         ptr_r <= ptr_nxt;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (clk_en && tif.isp_mode_active && tif.prog_stb) begin
         mem_r[ptr_r] <= tif.prog_byte;
      end
   end

   // =====================================================
   // address counter, data output and cascade hand-off
   logic [scp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic passed_r, passed_nxt, data_nxt, data_oe_nxt, ceo_n_nxt;
   logic enabled, stored_bit;
   assign enabled = !ce_s_r[1] && oe_s_r[1] && !oe_rst_oe_r;
   assign stored_bit = mem_r[addr_r[scp_pkg::ADDR_W-1:3]][addr_r[2:0]];
   always_comb begin
      addr_nxt = addr_r;
      passed_nxt = passed_r;
      if (!enabled) begin
         addr_nxt = scp_pkg::ADDR_ZERO;
         passed_nxt = 1'b0;
      end else if (cfg_rise && sel_s_r[1] && !passed_r) begin
         if (addr_r == scp_pkg::TERMINAL_COUNT) begin
            passed_nxt = 1'b1;
         end else begin
            addr_nxt = addr_r + scp_pkg::ADDR_ONE;
         end
      end
      // data follows the counter one cycle after it moves
      data_nxt = stored_bit;
      data_oe_nxt = enabled && !passed_r && !tif.isp_mode_active;
      ceo_n_nxt = !(enabled && passed_nxt);
   end

   // readout registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_r <= scp_pkg::ADDR_ZERO;
         passed_r <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe <= 1'b0;
         cascade_enable_out_n <= 1'b1;
      end else if (clk_en) begin
         addr_r <= addr_nxt;
         passed_r <= passed_nxt;
         serial_data_out <= data_nxt;
         serial_data_oe <= data_oe_nxt;
         cascade_enable_out_n <= ceo_n_nxt;
      end
   end
endmodule : scp_readout
`default_nettype wire

// ===== verif/scp_readout_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checker for the readout block
module scp_readout_monitor (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic chip_enable_n,
   input wire logic oe_reset_n_i,
   input wire logic oe_reset_n_o,
   input wire logic oe_reset_n_oe,
   input wire logic serial_data_oe,
   input wire logic cascade_enable_out_n,
   input wire logic config_pulse_n_o,
   input wire logic config_pulse_n_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] por_cnt_r, por_cnt_nxt, cf_cnt_r, cf_cnt_nxt;
   // cycles since reset (saturating) and length of the running pulse
   always_comb begin
      por_cnt_nxt = (por_cnt_r == 8'hFF) ? por_cnt_r : por_cnt_r + 8'h01;
      cf_cnt_nxt = config_pulse_n_oe ? cf_cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         por_cnt_r <= 8'h00;
         cf_cnt_r <= 8'h00;
      end else begin
         por_cnt_r <= por_cnt_nxt;
         cf_cnt_r <= cf_cnt_nxt;
      end
   end
   a_por_hold: assert property (por_cnt_r < 8'h46 |-> oe_reset_n_oe)
      else $error("reset line released early");
   a_por_end: assert property (por_cnt_r > 8'h5A |-> !oe_reset_n_oe)
      else $error("reset line held too long");
   a_por_drive: assert property (oe_reset_n_oe |-> !oe_reset_n_o && !serial_data_oe)
      else $error("reset line hold not low or data driven");
   a_oe_float: assert property (!oe_reset_n_i [*4] |-> !serial_data_oe)
      else $error("data driven while reset line low");
   a_ce_standby: assert property (chip_enable_n [*4] |-> !serial_data_oe)
      else $error("data driven in standby");
   a_casc_release: assert property ((chip_enable_n || !oe_reset_n_i) [*4] |-> cascade_enable_out_n)
      else $error("cascade stayed low");
   a_casc_entry: assert property ($fell(cascade_enable_out_n) |-> $past(!chip_enable_n && oe_reset_n_i, 3))
      else $error("cascade low without enables");
   a_pass_float: assert property ($fell(cascade_enable_out_n) |=> !serial_data_oe)
      else $error("data still driven after hand-off");
   a_cf_drive: assert property (config_pulse_n_oe |-> !config_pulse_n_o)
      else $error("config pulse drives high");
   a_cf_width: assert property ($fell(config_pulse_n_oe) |-> cf_cnt_r >= 8'h0C)
      else $error("config pulse too short");
endmodule : scp_readout_monitor
bind scp_readout scp_readout_monitor i_scp_readout_monitor (.ref_clk, .rstn, .chip_enable_n,
   .oe_reset_n_i, .oe_reset_n_o, .oe_reset_n_oe, .serial_data_oe, .cascade_enable_out_n,
   .config_pulse_n_o, .config_pulse_n_oe);
`default_nettype wire

// ===== verif/scp_loader_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// loading device: config clock, chip enable, share of reset wire
module scp_loader_model (
   input wire logic oe_reset_n_oe,
   output logic cfg_clk,
   output logic chip_enable_n,
   output logic oe_reset_n_i
);
   logic pull_low;
   initial begin
      cfg_clk = 1'b0;
      chip_enable_n = 1'b1;
      pull_low = 1'b0;
   end
   // open-drain wire with pull-up: anyone pulling wins
   assign oe_reset_n_i = (oe_reset_n_oe || pull_low) ? 1'b0 : 1'b1;
   // clock only inside a frame; enables set beforehand by caller
   task clocks(input int n);
      #13;
      repeat (n) begin
         cfg_clk = 1'b1;
         #100;
         cfg_clk = 1'b0;
         #100;
      end
   endtask : clocks
   task set_ce(input logic v);
      chip_enable_n = v;
   endtask : set_ce
   task pull(input logic v);
      pull_low = v;
   endtask : pull
endmodule : scp_loader_model
`default_nettype wire

// ===== verif/scp_readout_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module scp_readout_tb_top;
   logic ref_clk, rstn, clk_en, cfg_clk_sel, tck, tms, tdi;
   logic cfg_clk, chip_enable_n, oe_reset_n_i, oe_reset_n_o, oe_reset_n_oe;
   logic serial_data_out, serial_data_oe, cascade_enable_out_n;
   logic config_pulse_n_o, config_pulse_n_oe, tdo, tdo_oe, cf_wire;
   logic [7:0] cf_run, cf_last;
   int err_total, checks_done;
   // ==========
   // structure
   scp_loader_model ldr (.oe_reset_n_oe(oe_reset_n_oe), .cfg_clk(cfg_clk),
      .chip_enable_n(chip_enable_n), .oe_reset_n_i(oe_reset_n_i));
   scp_readout i_scp_readout (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .cfg_clk(cfg_clk),
      .cfg_clk_sel(cfg_clk_sel), .chip_enable_n(chip_enable_n), .oe_reset_n_i(oe_reset_n_i),
      .oe_reset_n_o(oe_reset_n_o), .oe_reset_n_oe(oe_reset_n_oe), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe), .cascade_enable_out_n(cascade_enable_out_n),
      .config_pulse_n_o(config_pulse_n_o), .config_pulse_n_oe(config_pulse_n_oe),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   // pulse line has a pull-up; measure how long it sits low
   assign cf_wire = config_pulse_n_oe ? config_pulse_n_o : 1'b1;
   always @(posedge ref_clk) begin
      if (cf_wire === 1'b0) begin
         cf_run <= cf_run + 8'h01;
      end else begin
         if (cf_run != 8'h00) cf_last <= cf_run;
         cf_run <= 8'h00;
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // ==========
   // helpers
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_of_test;
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // one test clock: phases of 4 cycles, tdo read before the rise
   task jbit(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      cyc(4);
      o = tdo_oe ? tdo : 1'b1;
      tck = 1'b1;
      cyc(4);
      tck = 1'b0;
   endtask : jbit
   task shift_ir(input logic [7:0] code);
      logic o;
      logic [7:0] cap;
      repeat (5) jbit(1'b1, 1'b1, o);
      jbit(1'b0, 1'b1, o);
      jbit(1'b1, 1'b1, o);
      jbit(1'b1, 1'b1, o);
      jbit(1'b0, 1'b1, o);
      jbit(1'b0, 1'b1, o);
      for (int i = 0; i < 8; i++) begin
         jbit(i == 7, code[i], o);
         cap[i] = o;
      end
      jbit(1'b1, 1'b1, o);
      jbit(1'b0, 1'b1, o);
      chk("ir capture", scp_pkg::IR_CAPTURE, cap);
   endtask : shift_ir
   // ==========
   // scenarios
   task t_por;
      int n;
      n = 0;
      while (oe_reset_n_oe === 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("power-on hold", 8'(scp_pkg::POR_CYCLES), 8'(n));
      if (n == 200) end_of_test();
      cyc(4);
   endtask : t_por
   task t_cascade;
      ldr.set_ce(1'b0);
      cyc(6);
      ldr.clocks(511);
      cyc(6);
      chk("cascade at tc", 8'h01, cascade_enable_out_n);
      ldr.clocks(1);
      cyc(6);
      chk("cascade past tc", 8'h00, cascade_enable_out_n);
      chk("data past tc", 8'h00, serial_data_oe);
      ldr.pull(1'b1);
      cyc(6);
      chk("cascade reset low", 8'h01, cascade_enable_out_n);
      ldr.pull(1'b0);
      cyc(6);
      ldr.clocks(511);
      cyc(6);
      chk("cascade after reset", 8'h01, cascade_enable_out_n);
      ldr.set_ce(1'b1);
      cyc(6);
      chk("data standby", 8'h00, serial_data_oe);
   endtask : t_cascade
   task t_sel;
      cfg_clk_sel = 1'b0;
      ldr.set_ce(1'b0);
      cyc(6);
      ldr.clocks(512);
      cyc(6);
      chk("cascade unselected", 8'h01, cascade_enable_out_n);
      cfg_clk_sel = 1'b1;
      cyc(6);
      ldr.clocks(512);
      cyc(6);
      chk("cascade selected", 8'h00, cascade_enable_out_n);
      ldr.set_ce(1'b1);
      cyc(6);
      chk("cascade ce high", 8'h01, cascade_enable_out_n);
   endtask : t_sel
   task t_config;
      shift_ir(scp_pkg::INS_CONFIG);
      cyc(30);
      chk("config pulse", 8'(scp_pkg::CF_PULSE_CYCLES), cf_last);
   endtask : t_config
   task t_isp;
      logic o;
      ldr.set_ce(1'b0);
      cyc(6);
      chk("data enabled", 8'h01, serial_data_oe);
      shift_ir(scp_pkg::INS_ISP_MODE_ACTIVE);
      cyc(6);
      chk("data isp", 8'h00, serial_data_oe);
      repeat (5) jbit(1'b1, 1'b1, o);
      cyc(6);
      chk("data isp left", 8'h01, serial_data_oe);
      ldr.set_ce(1'b1);
   endtask : t_isp
   // ==========
   // main sequence; idle test pins sit at their pull-up level
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      cfg_clk_sel = 1'b1;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      err_total = 0;
      checks_done = 0;
      cf_run = 8'h00;
      cf_last = 8'h00;
      cyc(4);
      rstn = 1'b1;
      t_por();
      t_cascade();
      t_sel();
      t_config();
      t_isp();
      end_of_test();
   end
endmodule : scp_readout_tb_top
`default_nettype wire
